// ==== dv/oec_eprom_model.sv ====
`timescale 1ns/10ps
module oec_eprom_model
   import oec_pkg::*;
#(
   parameter logic [7:0] MakerCode = 8'hcb, // arbitrary value, odd parity
   parameter logic [7:0] DevCode = 8'h23 // arbitrary value, odd parity
)(
   input wire oec_pkg::oec_pins_type pins,
   output logic [DataW-1:0] dataQ
);
   logic [DataW-1:0] mem [0:65535];
   logic [DataW-1:0] lastQ = 8'h00;
   wire isId = pins.identHv && pins.addrLines[15:10] == 6'h00 && pins.addrLines[8:1] == 8'h00;
   // lsb picks byte, both odd parity
   wire [7:0] idByte = pins.addrLines[0] ? DevCode : MakerCode;
   // drive only with select and gate low
   wire drive = !pins.selectN && !pins.gateN && !pins.gateHv;
   // released lines show inverse of last value, so a stale sample cannot pass
   assign dataQ = drive ? (isId ? idByte : mem[pins.addrLines]) : ~lastQ;
   always @(dataQ or drive) begin
      if (drive) begin
         lastQ = dataQ;
      end
   end
   initial begin
      foreach (mem[i]) mem[i] = ErasedByte;
   end
   // write only on a select pulse under program voltage
   always @(posedge pins.selectN) begin
      if (pins.gateHv && pins.supplyHigh) begin
         mem[pins.addrLines] = mem[pins.addrLines] & pins.dataOut;
      end
   end
endmodule // oec_eprom_model

// ==== dv/oec_host_checker.sv ====
`timescale 1ns/10ps
module oec_host_checker
   import oec_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic reqValid,
   input wire oec_pkg::oec_req_type req,
   input wire logic reqReady,
   input wire logic rspValid,
   input wire oec_pkg::oec_rsp_type rsp,
   input wire oec_pkg::oec_pins_type pins
);
   logic [CntW-1:0] lowCnt_q;
   logic inhibit_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lowCnt_q <= '0;
         inhibit_q <= 1'b0;
      end else begin
         lowCnt_q <= (!pins.selectN && pins.gateHv) ? lowCnt_q + 1'b1 : '0;
         if (reqValid && reqReady) begin
            inhibit_q <= req.cmd == OEC_CMD_INHIBIT;
         end
      end
   end
   a_hv_with_supply: assert property (pins.gateHv |-> pins.supplyHigh && pins.gateN)
      else $error("program voltage without supply or with gate low");
   a_pulse_width: assert property ($rose(pins.selectN) && pins.gateHv |-> lowCnt_q == CntW'(ProgPulseCyc))
      else $error("program pulse width wrong");
   a_pulse_stable: assert property (!pins.selectN && pins.gateHv |-> $stable(pins.addrLines) && $stable(pins.dataOut) && pins.dataOe)
      else $error("address or data moved during pulse");
   a_pulse_limit: assert property (rspValid |-> rsp.pulses <= 5'(MaxPulses))
      else $error("too many pulses");
   a_gate_after_sel: assert property ($fell(pins.gateN) |-> $past(pins.selectN, 33) == 1'b0)
      else $error("gate lowered too soon after select");
   a_gate_needs_sel: assert property (!pins.gateN |-> !pins.selectN && !pins.dataOe)
      else $error("gate low without select or with host driving");
   a_ident_lines: assert property (pins.identHv |-> pins.addrLines[15:10] == 6'h00 && pins.addrLines[8:1] == 8'h00)
      else $error("identify with upper lines not low");
   a_inhibit_hold: assert property (inhibit_q && pins.gateHv |-> pins.selectN)
      else $error("select pulsed on inhibited part");
   c_pulse: cover property ($rose(pins.selectN) && pins.gateHv);
   c_ident: cover property (pins.identHv && !pins.gateN);
   c_inhibit: cover property (inhibit_q && pins.gateHv);
endmodule // oec_host_checker

bind oec_host_ctrl oec_host_checker u_chk (.clk(clk), .nrst(nrst), .reqValid(reqValid), .req(req),
   .reqReady(reqReady), .rspValid(rspValid), .rsp(rsp), .pins(pins));

// ==== dv/oec_host_ctrl_bench.sv ====
`timescale 1ns/10ps
module oec_host_ctrl_bench;
   import oec_pkg::*;
   localparam logic [7:0] MakerId = 8'hcb; // arbitrary value
   localparam logic [7:0] DeviceId = 8'h23; // arbitrary value
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic reqValid = 1'b0;
   oec_req_type req = '0;
   logic reqReady;
   logic rspValid;
   oec_rsp_type rsp;
   oec_pins_type pins;
   logic [DataW-1:0] dataIn;
   int failCount = 0;
   int testsRun = 0;
   always #2 clk = ~clk;
   oec_host_ctrl u_dut (.clk(clk), .nrst(nrst), .reqValid(reqValid), .req(req),
      .reqReady(reqReady), .rspValid(rspValid), .rsp(rsp), .pins(pins), .dataIn(dataIn));
   oec_eprom_model #(.MakerCode(MakerId), .DevCode(DeviceId)) u_dev (.pins(pins), .dataQ(dataIn));
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      testsRun++;
      if (got !== exp) begin
         failCount++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one request, held over the taking edge, then a bounded wait for the answer
   task automatic op(input oec_cmd_type cmd, input logic [15:0] addr, input logic [7:0] data);
      int n;
      n = 0;
      @(negedge clk);
      req = '{cmd, addr, data};
      reqValid = 1'b1;
      @(negedge clk);
      reqValid = 1'b0;
      while (rspValid !== 1'b1 && n < 40000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 40000) begin
         failCount++;
         $display("Error answer expected 1 seen 0");
      end
   endtask
   task automatic t_erased();
      op(OEC_CMD_READ, 16'h1234, 8'h00);
      chk("erased byte", ErasedByte, rsp.data);
      chk("idle select", 8'h01, 8'(pins.selectN));
      chk("idle gate", 8'h01, 8'(pins.gateN));
      chk("idle supply", 8'h00, 8'(pins.supplyHigh));
      chk("idle drive", 8'h00, 8'(pins.dataOe));
      chk("ready", 8'h01, 8'(reqReady));
   endtask
   task automatic t_identify();
      for (int i = 0; i < 2; i++) begin
         op(OEC_CMD_IDENT, 16'(i), 8'h00);
         chk("id byte", (i == 1) ? DeviceId : MakerId, rsp.data);
         chk("id parity", 8'h01, 8'(^rsp.data));
         chk("parity flag", 8'h01, 8'(rsp.parityOk));
         chk("id ok", 8'h01, 8'(rsp.ok));
      end
   endtask
   task automatic t_program();
      op(OEC_CMD_PROGRAM, 16'h0042, 8'h5a);
      chk("program ok", 8'h01, 8'(rsp.ok));
      chk("pulse count", 8'h01, 8'(rsp.pulses));
      op(OEC_CMD_READ, 16'h0042, 8'h00);
      chk("readback", 8'h5a, rsp.data);
   endtask
   task automatic t_inhibit();
      op(OEC_CMD_INHIBIT, 16'h0043, 8'h00);
      chk("inhibit verify", ErasedByte, rsp.data);
      chk("inhibit ok", 8'h00, 8'(rsp.ok));
      op(OEC_CMD_READ, 16'h0043, 8'h00);
      chk("inhibited byte", ErasedByte, rsp.data);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      t_erased();
      t_identify();
      t_program();
      t_inhibit();
      conclude();
   end
   // two program runs of about 26k cycles each, plus margin
   initial begin
      #(4 * 75000);
      failCount++;
      conclude();
   end
endmodule // oec_host_ctrl_bench

// ==== rtl/oec_delay_cnt.sv ====
`timescale 1ns/10ps
module oec_delay_cnt
   import oec_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic [CntW-1:0] cycles,
   output logic done
);
   logic [CntW-1:0] cnt_q;
   logic busy_q;
   wire logic lastCyc = busy_q && (cnt_q == CntW'(1));

   assign done = lastCyc;

   // counts cycles after start; done pulses on the last one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
      end else if (start) begin
         cnt_q <= cycles;
         busy_q <= 1'b1;
      end else if (busy_q) begin
         cnt_q <= cnt_q - CntW'(1);
         busy_q <= !lastCyc;
      end
   end
endmodule // oec_delay_cnt

// ==== rtl/oec_host_ctrl.sv ====
`timescale 1ns/10ps
// What this block does
// - host drives the whole byte on the eight data lines while programming
// - per byte: address and data stable, then one 100us low select pulse
// - on verify failure pulse again, at most 25 pulses per byte
// - select held high inhibits programming of a ganged part
// - verify drives gate and select low, samples after verify delay
// - identify: high voltage on line 9, other lines low, lsb picks byte
module oec_host_ctrl
   import oec_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic reqValid,
   input wire oec_pkg::oec_req_type req,
   output logic reqReady,
   output logic rspValid,
   output oec_pkg::oec_rsp_type rsp,
   output oec_pkg::oec_pins_type pins,
   input wire logic [DataW-1:0] dataIn
);
   import oec_pkg::*;

   typedef enum logic [7:0] {
      IDLE = 8'h01,
      SETUP = 8'h02,
      PULSE = 8'h04,
      HOLD = 8'h08,
      SELECT = 8'h10,
      GATE = 8'h20,
      FLOAT = 8'h40,
      DONE = 8'h80
   } oec_state_type;

   oec_state_type state_q;
   oec_req_type cur_q;
   oec_pins_type pins_q;
   oec_rsp_type rsp_q;
   logic rspValid_q;
   logic reqReady_q;
   logic [4:0] pulses_q;
   logic [DataW-1:0] sync1_q;
   logic [DataW-1:0] sync2_q;
   logic start;
   logic [CntW-1:0] cycles;
   logic done;

   // pin data passes two flops before use
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= dataIn;
         sync2_q <= sync1_q;
      end
   end

   wire logic isProg = (cur_q.cmd == OEC_CMD_PROGRAM) || (cur_q.cmd == OEC_CMD_INHIBIT);
   wire logic isIdent = cur_q.cmd == OEC_CMD_IDENT;
   // verify on the captured byte; the released bus shows junk later
   wire logic match = rsp_q.data == cur_q.data;
   wire logic parityOdd = ^sync2_q;
   wire logic budgetLeft = pulses_q < 5'(MaxPulses);
   // only a real program retries; an inhibited part was never pulsed
   wire logic retry = (cur_q.cmd == OEC_CMD_PROGRAM) && !match && budgetLeft;
   // identify address: lsb kept, all others low
   wire logic [AddrW-1:0] identAddr = {{(AddrW-1){1'b0}}, req.addr[0]};
   wire logic [AddrW-1:0] busAddr = (req.cmd == OEC_CMD_IDENT) ? identAddr : req.addr;
   // gate falls after select held access minus gate delay
   wire logic [CntW-1:0] preGate = CntW'(AccessCyc - GateCyc);
   // wait before sampling, worst of the two paths
   wire logic [CntW-1:0] postGate = CntW'(GateCyc + 2);

   oec_delay_cnt u_delay (
      .clk(clk),
      .nrst(nrst),
      .start(start),
      .cycles(cycles),
      .done(done)
   );

   always_comb begin
      start = 1'b0;
      cycles = '0;
      case (state_q)
         IDLE: begin
            start = reqValid;
            cycles = (req.cmd == OEC_CMD_PROGRAM || req.cmd == OEC_CMD_INHIBIT) ?
               CntW'(SetupCyc) : preGate;
         end
         SETUP: begin
            start = done;
            cycles = CntW'(ProgPulseCyc);
         end
         PULSE: begin
            start = done;
            cycles = CntW'(HoldCyc);
         end
         HOLD: begin
            start = done;
            cycles = preGate;
         end
         SELECT: begin
            start = done;
            cycles = postGate;
         end
         GATE: begin
            start = done;
            cycles = CntW'(FloatCyc);
         end
         FLOAT: begin
            start = done && retry;
            cycles = CntW'(SetupCyc);
         end
         default: begin
            start = 1'b0;
            cycles = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= IDLE;
         cur_q <= '0;
         pulses_q <= '0;
         rsp_q <= '0;
         rspValid_q <= 1'b0;
         reqReady_q <= 1'b1;
         // idle in standby, data lines released
         pins_q <= '{addrLines: '0, selectN: 1'b1, gateN: 1'b1, gateHv: 1'b0,
            supplyHigh: 1'b0, identHv: 1'b0, dataOut: ErasedByte, dataOe: 1'b0};
      end else begin
         rspValid_q <= 1'b0;
         case (state_q)
            IDLE: begin
               pulses_q <= '0;
               if (reqValid) begin
                  cur_q <= req;
                  reqReady_q <= 1'b0;
                  pins_q.addrLines <= busAddr;
                  if (req.cmd == OEC_CMD_PROGRAM || req.cmd == OEC_CMD_INHIBIT) begin
                     pins_q.gateHv <= 1'b1;
                     pins_q.supplyHigh <= 1'b1;
                     // whole byte on the data lines
                     pins_q.dataOut <= req.data;
                     pins_q.dataOe <= 1'b1;
                     state_q <= SETUP;
                  end else begin
                     // identify voltage on line 9, other lines low except the lsb
                     if (req.cmd == OEC_CMD_IDENT) begin
                        pins_q.identHv <= 1'b1;
                     end
                     // select falls on the same edge the address is set
                     pins_q.selectN <= 1'b0;
                     state_q <= SELECT;
                  end
               end
            end
            SETUP: begin
               if (done) begin
                  // inhibit keeps select high under program voltage
                  pins_q.selectN <= cur_q.cmd == OEC_CMD_INHIBIT;
                  pulses_q <= pulses_q + 5'(1);
                  state_q <= PULSE;
               end
            end
            PULSE: begin
               if (done) begin
                  pins_q.selectN <= 1'b1;
                  state_q <= HOLD;
               end
            end
            HOLD: begin
               if (done) begin
                  // verify: gate back to low level, data released, select low
                  pins_q.gateHv <= 1'b0;
                  pins_q.dataOe <= 1'b0;
                  pins_q.selectN <= 1'b0;
                  state_q <= SELECT;
               end
            end
            SELECT: begin
               if (done) begin
                  // gate low only while this part is selected
                  pins_q.gateN <= 1'b0;
                  state_q <= GATE;
               end
            end
            GATE: begin
               if (done) begin
                  rsp_q.data <= sync2_q;
                  rsp_q.parityOk <= parityOdd;
                  rsp_q.pulses <= pulses_q;
                  pins_q.gateN <= 1'b1;
                  pins_q.selectN <= 1'b1;
                  state_q <= FLOAT;
               end
            end
            FLOAT: begin
               if (done) begin
                  if (retry) begin
                     // another pulse for a failing byte
                     pins_q.gateHv <= 1'b1;
                     pins_q.dataOut <= cur_q.data;
                     pins_q.dataOe <= 1'b1;
                     state_q <= SETUP;
                  end else begin
                     // result handed back; supply returns to normal
                     rsp_q.ok <= isProg ? match : (isIdent ? rsp_q.parityOk : 1'b1);
                     pins_q.supplyHigh <= 1'b0;
                     pins_q.identHv <= 1'b0;
                     state_q <= DONE;
                  end
               end
            end
            DONE: begin
               rspValid_q <= 1'b1;
               reqReady_q <= 1'b1;
               state_q <= IDLE;
            end
            default: begin
               reqReady_q <= 1'b1;
               state_q <= IDLE;
            end
         endcase
      end
   end

   assign reqReady = reqReady_q;
   assign rspValid = rspValid_q;
   assign rsp = rsp_q;
   assign pins = pins_q;
endmodule // oec_host_ctrl

// ==== rtl/oec_pkg.sv ====
package oec_pkg;
   // pin timing, in ns as printed
   localparam int ProgPulseNs = 100000;
   localparam int AccessNs = 250;
   localparam int GateNs = 120;
   localparam int FloatNs = 70;
   localparam int SetupNs = 2000;
   localparam int HoldNs = 2000;
   localparam int ClkNs = 4;
   // least times round up to whole cycles
   localparam int ProgPulseCyc = (ProgPulseNs + ClkNs - 1) / ClkNs;
   localparam int AccessCyc = (AccessNs + ClkNs - 1) / ClkNs;
   localparam int GateCyc = (GateNs + ClkNs - 1) / ClkNs;
   localparam int FloatCyc = (FloatNs + ClkNs - 1) / ClkNs;
   localparam int SetupCyc = (SetupNs + ClkNs - 1) / ClkNs;
   localparam int HoldCyc = (HoldNs + ClkNs - 1) / ClkNs;
   localparam int MaxPulses = 25;
   localparam int AddrW = 16;
   localparam int DataW = 8;
   localparam int CntW = 20;
   localparam logic [7:0] ErasedByte = 8'hff;
   localparam int IdentifyBit = 9;

   typedef enum logic [2:0] {
      OEC_CMD_READ = 3'h0,
      OEC_CMD_PROGRAM = 3'h1,
      OEC_CMD_IDENT = 3'h2,
      OEC_CMD_INHIBIT = 3'h3
   } oec_cmd_type;

   typedef struct packed {
      oec_cmd_type cmd;
      logic [AddrW-1:0] addr;
      logic [DataW-1:0] data;
   } oec_req_type;

   typedef struct packed {
      logic [DataW-1:0] data;
      logic ok;
      logic parityOk;
      logic [4:0] pulses;
   } oec_rsp_type;

   // pins toward the device; gateHv requests program voltage on the gate pin
   typedef struct packed {
      logic [AddrW-1:0] addrLines;
      logic selectN;
      logic gateN;
      logic gateHv;
      logic supplyHigh;
      logic identHv;
      logic [DataW-1:0] dataOut;
      logic dataOe;
   } oec_pins_type;
endpackage
